// File: scp_pkg.sv
// Constants shared by both ends of the serial configuration port.
// Assumes a 40 MHz system clock on both ends.
package scp_pkg;

    // ------------------------------------------------------------------
    // Frame layout
    // ------------------------------------------------------------------
    localparam int SCP_AW     = 7;
    localparam int SCP_DW     = 16;
    localparam int SCP_FRAME  = 24;
    localparam int SCP_NREG   = 12;
    localparam int SCP_TEMP_W = 9;

    // ------------------------------------------------------------------
    // Device register map
    // ------------------------------------------------------------------
    localparam logic [3:0] SCP_IDX_NONE = 4'hf;
    localparam logic [3:0] SCP_IDX_TEMP = 4'h6;
    localparam logic [3:0] SCP_IDX_RST  = 4'h7;
    localparam logic [SCP_AW-1:0] SCP_ADDR [SCP_NREG] = '{
        7'h00, 7'h01, 7'h02, 7'h03, 7'h0e, 7'h0f,
        7'h2b, 7'h2c, 7'h37, 7'h38, 7'h3a, 7'h66};
    localparam logic [SCP_DW-1:0] SCP_DEF [SCP_NREG] = '{
        16'h0000, 16'h4000, 16'h0780, 16'h4b18, 16'haaa8, 16'ha000,
        16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
    localparam logic [SCP_DW-1:0] SCP_RST_KEY = 16'hd2f0;
    localparam int SCP_B_FOUR = 15;
    localparam int SCP_B_DEC  = 14;
    localparam int SCP_B_BAND = 12;

    // ------------------------------------------------------------------
    // Controller timing
    // ------------------------------------------------------------------
    localparam int SCP_CLK_MHZ  = 40;
    localparam int SCP_HALF_NS  = 200;
    localparam int SCP_HALF_CYC = (SCP_HALF_NS * SCP_CLK_MHZ + 999) / 1000;

    // ------------------------------------------------------------------
    // Controller Wishbone map
    // ------------------------------------------------------------------
    localparam logic [3:0] SCP_WB_CTRL  = 4'h0;
    localparam logic [3:0] SCP_WB_WDATA = 4'h4;
    localparam logic [3:0] SCP_WB_RDATA = 4'h8;
    localparam logic [3:0] SCP_WB_STAT  = 4'hc;
    localparam int SCP_C_START = 0;
    localparam int SCP_C_RW    = 1;
    localparam int SCP_C_FOUR  = 2;
    localparam int SCP_C_INIT  = 3;
    localparam int SCP_C_ADDR  = 8;

    // Maps a register address to its storage index.
    function automatic logic [3:0] scp_idx(input logic [SCP_AW-1:0] a);
        scp_idx = SCP_IDX_NONE;
        for (int i = 0; i < SCP_NREG; i++) begin
            if (SCP_ADDR[i] == a) begin
                scp_idx = 4'(i);
            end
        end
    endfunction

endpackage

// File: scp_link_if.sv
// Link between controller and converter serial configuration port.
// Assumes a pull-up on the shared data line when nobody drives it.
`timescale 1ns/1ps
interface scp_link_if;
    logic sclk;
    logic serial_select_n;
    logic hardware_init_pin_n;
    logic h_sdata_o;
    logic h_sdata_oe;
    logic d_sdata_o;
    logic d_sdata_oe;
    logic serial_output_pin;
    logic sdata_line;

    assign sdata_line = h_sdata_oe ? h_sdata_o :
                        (d_sdata_oe ? d_sdata_o : 1'b1);

    modport host (
        output sclk, serial_select_n, hardware_init_pin_n,
        output h_sdata_o, h_sdata_oe,
        input  sdata_line, serial_output_pin
    );
    modport dev (
        input  sclk, serial_select_n, hardware_init_pin_n, sdata_line,
        output d_sdata_o, d_sdata_oe, serial_output_pin
    );
endinterface

// File: scp_dev.sv
// Converter end of the serial configuration port: register file and
// serial slave. Assumes every link pin is asynchronous to clk_i and the
// serial clock runs far slower than clk_i.
//
// Behaviour
// [R1] Three-wire default: select, clock, shared data.
// [R2] Four-wire entered by write; reads on output.
// [R3] Frame is 8 address then 16 data.
// [R4] First rising edge captures direction bit.
// [R5] Controller raises select between transfers.
// [R6] Low init pin restores register defaults.
// [R7] Reset register write loads defaults, self-clears.
// [R8] Write sends zero then seven address bits.
// [R9] Write data bits sampled on rising edges.
// [R10] Read request blocks further register writes.
// [R11] Read shifts all sixteen bits out.
// [R12] Controller captures read bits on rising edge.
// [R13] Writes re-enabled by later zero direction.
// [R14] One write updates whole register at once.
// [R15] Register zero bit 15 selects wire mode.
// [R16] Register zero bit 14 enables decimation.
// [R17] Enable decimation before using band select.
// [R18] Only the key pattern triggers software reset.
// [R19] MSB first, data follows address directly.
// [R20] Shared line driven only in read data.
//
// The Wishbone slave port was chosen for this implementation.
`timescale 1ns/1ps
module scp_dev (
    // System
    input  wire logic                        clk_i,
    input  wire logic                        rst_i,
    // Link
    scp_link_if.dev                          link,
    // User side
    input  wire logic [scp_pkg::SCP_TEMP_W-1:0] temp_i,
    output logic                             four_wire_o,
    output logic                             dec_en_o,
    output logic                             band_sel_o
);
    import scp_pkg::*;

    // ------------------------------------------------------------------
    // Types and storage
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        SCPD_IDLE = 2'b00,
        SCPD_ADDR = 2'b01,
        SCPD_DATA = 2'b11,
        SCPD_DONE = 2'b10
    } scpd_phase_e;

    scpd_phase_e         phase_r;
    logic [SCP_DW-1:0]   regs_r [SCP_NREG];
    logic [3:0]          s1_r;
    logic [3:0]          s2_r;
    logic [3:0]          s3_r;
    logic [4:0]          cnt_r;
    logic                rw_r;
    logic                blk_r;
    logic [SCP_AW-1:0]   addr_r;
    logic [SCP_DW-1:0]   in_sh_r;
    logic [SCP_DW-1:0]   rd_sh_r;
    logic                sdata_r;
    logic                sdata_oe_r;
    logic                sdo_r;
    logic                four_r;
    logic                dec_r;
    logic                band_r;

    logic                sclk_s;
    logic                sel_s;
    logic                sdi;
    logic                init_n_s;
    logic                rise;
    logic                fall;
    logic                sel_fall;
    logic                sel_rise;
    logic                dev_rst;
    logic [SCP_AW-1:0]   addr_nxt;
    logic [3:0]          rd_idx;
    logic [3:0]          wr_idx;
    logic [SCP_DW-1:0]   wr_data;
    logic [SCP_DW-1:0]   rd_val;
    logic                commit;
    logic                soft_rst;
    logic                wr_en;

    // ------------------------------------------------------------------
    // Pin synchronisers and edge detection
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        s1_r <= {link.hardware_init_pin_n, link.sdata_line,
                 link.serial_select_n, link.sclk};
        s2_r <= s1_r;
        s3_r <= s2_r;
    end

    assign sclk_s   = s2_r[0];
    assign sel_s    = s2_r[1];
    assign sdi      = s2_r[2];
    assign init_n_s = s2_r[3];
    assign rise     = sclk_s & ~s3_r[0] & ~sel_s;
    assign fall     = ~sclk_s & s3_r[0] & ~sel_s;
    assign sel_fall = ~sel_s & s3_r[1];
    assign sel_rise = sel_s & ~s3_r[1];
    assign dev_rst  = rst_i | ~init_n_s; // [R6]

    // ------------------------------------------------------------------
    // Frame sequencing
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (dev_rst || sel_rise) begin
            phase_r <= SCPD_IDLE; // [R5]
            cnt_r   <= 5'd0;
        end else if (sel_fall) begin
            phase_r <= SCPD_ADDR; // [R1]
            cnt_r   <= 5'd0;
        end else if (rise) begin
            case (phase_r)
                SCPD_ADDR: begin
                    cnt_r <= cnt_r + 5'd1;
                    if (cnt_r == 5'(SCP_AW)) begin
                        phase_r <= SCPD_DATA; // [R3] [R19]
                    end
                end
                SCPD_DATA: begin
                    cnt_r <= cnt_r + 5'd1;
                    if (cnt_r == 5'(SCP_FRAME - 1)) begin
                        phase_r <= SCPD_DONE; // [R3]
                    end
                end
                default: begin
                    cnt_r <= cnt_r;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Input shifting, direction and address capture
    // ------------------------------------------------------------------
    assign addr_nxt = {in_sh_r[SCP_AW-2:0], sdi};
    assign rd_idx   = scp_idx(addr_nxt);
    assign wr_idx   = scp_idx(addr_r);
    assign wr_data  = {in_sh_r[SCP_DW-2:0], sdi};

    always_ff @(posedge clk_i) begin
        if (dev_rst) begin
            in_sh_r <= '0;
            rw_r    <= 1'b0;
            blk_r   <= 1'b0;
            addr_r  <= '0;
        end else if (rise && phase_r != SCPD_DONE
                     && phase_r != SCPD_IDLE) begin
            in_sh_r <= wr_data; // [R9] [R19]
            if (phase_r == SCPD_ADDR && cnt_r == 5'd0) begin
                rw_r  <= sdi; // [R4]
                blk_r <= sdi; // [R10] [R13]
            end
            if (phase_r == SCPD_ADDR && cnt_r == 5'(SCP_AW)) begin
                addr_r <= addr_nxt; // [R8]
            end
        end
    end

    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    assign commit   = rise && phase_r == SCPD_DATA
                      && cnt_r == 5'(SCP_FRAME - 1)
                      && !rw_r && !blk_r; // [R10] [R13]
    assign soft_rst = commit && wr_idx == SCP_IDX_RST
                      && wr_data == SCP_RST_KEY; // [R18]
    assign wr_en    = commit && wr_idx != SCP_IDX_NONE
                      && wr_idx != SCP_IDX_TEMP
                      && wr_idx != SCP_IDX_RST;

    always_ff @(posedge clk_i) begin
        if (dev_rst || soft_rst) begin
            for (int i = 0; i < SCP_NREG; i++) begin
                regs_r[i] <= SCP_DEF[i]; // [R6] [R7]
            end
        end else if (wr_en) begin
            regs_r[wr_idx] <= wr_data; // [R14]
        end
    end

    always_comb begin
        if (rd_idx == SCP_IDX_NONE || rd_idx == SCP_IDX_RST) begin
            rd_val = '0; // [R7]
        end else if (rd_idx == SCP_IDX_TEMP) begin
            rd_val = {{(SCP_DW - SCP_TEMP_W){1'b0}}, temp_i};
        end else begin
            rd_val = regs_r[rd_idx];
        end
    end

    // ------------------------------------------------------------------
    // Read data output
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (dev_rst || sel_rise) begin
            rd_sh_r    <= '0;
            sdata_r    <= 1'b0;
            sdata_oe_r <= 1'b0; // [R20]
            sdo_r      <= 1'b0;
        end else if (rise && phase_r == SCPD_ADDR
                     && cnt_r == 5'(SCP_AW) && rw_r) begin
            rd_sh_r <= rd_val; // [R11]
        end else if (fall && phase_r == SCPD_DATA && rw_r) begin
            rd_sh_r <= {rd_sh_r[SCP_DW-2:0], 1'b0}; // [R11] [R12]
            sdata_r <= rd_sh_r[SCP_DW-1];
            sdo_r   <= four_r & rd_sh_r[SCP_DW-1]; // [R2]
            if (!four_r) begin
                sdata_oe_r <= 1'b1; // [R1] [R20]
            end
        end
    end

    // ------------------------------------------------------------------
    // Configuration outputs
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            four_r <= 1'b0;
            dec_r  <= 1'b0;
            band_r <= 1'b0;
        end else begin
            four_r <= regs_r[0][SCP_B_FOUR]; // [R2] [R15]
            dec_r  <= regs_r[0][SCP_B_DEC]; // [R16]
            band_r <= regs_r[0][SCP_B_BAND]; // [R17]
        end
    end

    assign four_wire_o            = four_r;
    assign dec_en_o               = dec_r;
    assign band_sel_o             = band_r;
    assign link.d_sdata_o         = sdata_r;
    assign link.d_sdata_oe        = sdata_oe_r;
    assign link.serial_output_pin = sdo_r;

endmodule

// File: scp_host.sv
// Controller end of the serial configuration port with a Wishbone
// classic slave for software. Assumes the device samples on rising
// serial clock edges and drives read data after falling ones.
`timescale 1ns/1ps
module scp_host (
    // System
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Link
    scp_link_if.host         link
);
    import scp_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        SCPH_IDLE = 3'b000,
        SCPH_LO   = 3'b001,
        SCPH_HI   = 3'b011,
        SCPH_END  = 3'b010,
        SCPH_GAP  = 3'b110
    } scph_state_e;

    scph_state_e             st_r;
    logic [7:0]              tmr_r;
    logic [4:0]              bit_r;
    logic [SCP_FRAME-1:0]    sh_r;
    logic [SCP_DW-1:0]       rx_r;
    logic [SCP_DW-1:0]       rdata_r;
    logic [SCP_DW-1:0]       wdata_r;
    logic [SCP_AW-1:0]       addr_r;
    logic                    rw_r;
    logic                    four_r;
    logic                    init_r;
    logic                    sclk_r;
    logic                    sel_n_r;
    logic                    do_r;
    logic                    oe_r;
    logic                    init_n_r;
    logic                    ack_r;
    logic [31:0]             dat_r;
    logic [1:0]              s1_r;
    logic [1:0]              s2_r;
    logic                    acc;
    logic                    start;
    logic                    tdone;
    logic                    din;
    logic [SCP_AW-1:0]       addr_nxt;

    assign acc   = wb_cyc_i & wb_stb_i & ~ack_r;
    assign start = acc && wb_we_i && wb_adr_i == SCP_WB_CTRL && wb_sel_i[0]
                   && wb_dat_i[SCP_C_START] && st_r == SCPH_IDLE;
    assign tdone = tmr_r == 8'(SCP_HALF_CYC - 1);
    assign din   = four_r ? s2_r[1] : s2_r[0];
    assign addr_nxt = wb_sel_i[1] ? wb_dat_i[SCP_C_ADDR +: SCP_AW]
                                  : addr_r;

    // ------------------------------------------------------------------
    // Wishbone registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r   <= 1'b0;
            dat_r   <= '0;
            wdata_r <= '0;
            addr_r  <= '0;
            rw_r    <= 1'b0;
            four_r  <= 1'b0;
            init_r  <= 1'b0;
        end else begin
            ack_r <= acc;
            if (acc && wb_we_i && st_r == SCPH_IDLE) begin
                if (wb_adr_i == SCP_WB_CTRL && wb_sel_i[0]) begin
                    rw_r   <= wb_dat_i[SCP_C_RW];
                    four_r <= wb_dat_i[SCP_C_FOUR];
                    init_r <= wb_dat_i[SCP_C_INIT];
                end
                if (wb_adr_i == SCP_WB_CTRL && wb_sel_i[1]) begin
                    addr_r <= wb_dat_i[SCP_C_ADDR +: SCP_AW];
                end
                if (wb_adr_i == SCP_WB_WDATA && wb_sel_i[0]) begin
                    wdata_r[7:0] <= wb_dat_i[7:0];
                end
                if (wb_adr_i == SCP_WB_WDATA && wb_sel_i[1]) begin
                    wdata_r[15:8] <= wb_dat_i[15:8];
                end
            end
            if (acc) begin
                case (wb_adr_i)
                    SCP_WB_CTRL:  dat_r <= {17'h0, addr_r, 4'h0,
                                            init_r, four_r, rw_r, 1'b0};
                    SCP_WB_WDATA: dat_r <= {16'h0, wdata_r};
                    SCP_WB_RDATA: dat_r <= {16'h0, rdata_r};
                    SCP_WB_STAT:  dat_r <= {31'h0, st_r != SCPH_IDLE};
                    default:      dat_r <= '0;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Serial engine
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        s1_r <= {link.serial_output_pin, link.sdata_line};
        s2_r <= s1_r;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r    <= SCPH_IDLE;
            tmr_r   <= '0;
            bit_r   <= '0;
            sh_r    <= '0;
            rx_r    <= '0;
            rdata_r <= '0;
            sclk_r  <= 1'b0;
            sel_n_r <= 1'b1;
            do_r    <= 1'b0;
            oe_r    <= 1'b0;
        end else begin
            tmr_r <= tdone ? 8'd0 : tmr_r + 8'd1;
            case (st_r)
                SCPH_IDLE: begin
                    tmr_r <= '0;
                    if (start) begin
                        sel_n_r <= 1'b0;
                        sh_r    <= {wb_dat_i[SCP_C_RW], addr_nxt,
                                    wdata_r}; // [R8] [R19]
                        do_r    <= wb_dat_i[SCP_C_RW]; // [R8]
                        oe_r    <= 1'b1;
                        bit_r   <= '0;
                        st_r    <= SCPH_LO;
                    end
                end
                SCPH_LO: begin
                    if (tdone) begin
                        sclk_r <= 1'b1;
                        rx_r   <= {rx_r[SCP_DW-2:0], din}; // [R12]
                        st_r   <= SCPH_HI;
                    end
                end
                SCPH_HI: begin
                    if (tdone) begin
                        sclk_r <= 1'b0;
                        if (bit_r == 5'(SCP_FRAME - 1)) begin
                            st_r <= SCPH_END;
                        end else begin
                            bit_r <= bit_r + 5'd1;
                            sh_r  <= {sh_r[SCP_FRAME-2:0], 1'b0};
                            do_r  <= sh_r[SCP_FRAME-2];
                            oe_r  <= four_r | ~rw_r
                                     | (bit_r < 5'(SCP_AW));
                            st_r  <= SCPH_LO;
                        end
                    end
                end
                SCPH_END: begin
                    if (tdone) begin
                        sel_n_r <= 1'b1; // [R5]
                        oe_r    <= 1'b0;
                        rdata_r <= rx_r;
                        st_r    <= SCPH_GAP;
                    end
                end
                default: begin
                    if (tdone) begin
                        st_r <= SCPH_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            init_n_r <= 1'b1;
        end else begin
            init_n_r <= ~init_r;
        end
    end

    assign wb_dat_o                 = dat_r;
    assign wb_ack_o                 = ack_r;
    assign link.sclk                = sclk_r;
    assign link.serial_select_n     = sel_n_r;
    assign link.hardware_init_pin_n = init_n_r;
    assign link.h_sdata_o           = do_r;
    assign link.h_sdata_oe          = oe_r;

endmodule

// File: scp_link_chk.sv
// Checker for the link between the two ends of the configuration port.
// Assumes the testbench feeds it the link signals and the system clock.
`timescale 1ns/1ps
module scp_link_chk (
    // System
    input wire logic clk_i,
    input wire logic rst_i,
    // Link
    input wire logic sclk,
    input wire logic serial_select_n,
    input wire logic h_sdata_oe,
    input wire logic d_sdata_oe,
    input wire logic serial_output_pin
);
    logic       sclk_r;
    logic [4:0] edge_cnt_r;

    // Counts rising serial clock edges inside a frame.
    always_ff @(posedge clk_i) begin
        sclk_r <= sclk;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || serial_select_n) begin
            edge_cnt_r <= 5'h00;
        end else if (sclk && !sclk_r) begin
            edge_cnt_r <= edge_cnt_r + 5'h01;
        end
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    bus_fight_a: assert property (!(h_sdata_oe && d_sdata_oe))
        else $error("both ends drive the shared line");
    sel_idle_a: assert property (serial_select_n |-> !sclk)
        else $error("serial clock moves outside a frame");
    sel_gap_a: assert property ($rose(serial_select_n) |->
        serial_select_n[*8]) else $error("select gap too short");
    high_half_a: assert property ($rose(sclk) |-> sclk[*8])
        else $error("serial clock high phase wrong");
    low_half_a: assert property ($fell(sclk) |-> (!sclk)[*8])
        else $error("serial clock low phase wrong");
    frame_len_a: assert property ($rose(serial_select_n) |->
        edge_cnt_r == 5'h18) else $error("frame is not 24 bits");
    data_phase_a: assert property (d_sdata_oe && !serial_select_n |->
        edge_cnt_r >= 5'h08) else $error("device drives in address");
    oe_release_a: assert property ($rose(serial_select_n) |->
        ##[1:5] !d_sdata_oe) else $error("device keeps shared line");
    sdo_quiet_a: assert property (serial_output_pin |-> !d_sdata_oe)
        else $error("device drives both data pins");
endmodule

// File: testbench.sv
// Testbench joining controller and device over the link interface.
// Assumes the package, interface, both ends and the checker are compiled.
`timescale 1ns/1ps
module testbench;
    import scp_pkg::*;
    logic        clk_i;
    logic        rst_i;
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [3:0]  adr;
    logic [31:0] wdat;
    logic [31:0] rdat;
    logic [31:0] last;
    logic        ack;
    logic [8:0]  temp;
    logic        four_wire;
    logic        dec_en;
    logic        band_sel;
    logic [31:0] seed;
    logic [15:0] v;
    logic [15:0] mdl [SCP_NREG];
    logic [15:0] exp_q [$];
    int          failures;
    int          cmp_count;

    scp_link_if scp_link_if_i ();
    scp_host scp_host_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .link(scp_link_if_i.host));
    scp_dev scp_dev_i (.clk_i(clk_i), .rst_i(rst_i),
        .link(scp_link_if_i.dev), .temp_i(temp), .four_wire_o(four_wire),
        .dec_en_o(dec_en), .band_sel_o(band_sel));
    scp_link_chk scp_link_chk_i (.clk_i(clk_i), .rst_i(rst_i),
        .sclk(scp_link_if_i.sclk),
        .serial_select_n(scp_link_if_i.serial_select_n),
        .h_sdata_oe(scp_link_if_i.h_sdata_oe),
        .d_sdata_oe(scp_link_if_i.d_sdata_oe),
        .serial_output_pin(scp_link_if_i.serial_output_pin));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        xs = t ^ (t << 5);
    endfunction

    task automatic complete_run();
        if (failures == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [15:0] e,
                         input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Classic Wishbone cycle; read data lands in last.
    task automatic wb(input logic w, input logic [3:0] a,
                      input logic [31:0] d);
        int n;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= 4'hf;
        adr <= a;
        wdat <= d;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (n >= 20) begin
            failures++;
            complete_run();
        end
        last = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    // One link frame started by software, then polled to completion.
    task automatic xfer(input logic rw, input logic fw,
                        input logic [6:0] a, input logic [15:0] d);
        int n;
        wb(1'b1, SCP_WB_WDATA, {16'h0000, d});
        wb(1'b1, SCP_WB_CTRL, {17'h00000, a, 5'h00, fw, rw, 1'b1});
        n = 0;
        do begin
            wb(1'b0, SCP_WB_STAT, 32'h0);
            n++;
        end while (last[0] !== 1'b0 && n < 300);
        if (n >= 300) begin
            failures++;
            complete_run();
        end
        if (rw) begin
            wb(1'b0, SCP_WB_RDATA, 32'h0);
        end
    endtask

    task automatic rd(input logic [6:0] a, input logic [15:0] e,
                      input logic fw);
        exp_q.push_back(e);
        xfer(1'b1, fw, a, 16'h0000);
    endtask

    task automatic rdall(input logic fw);
        for (int i = 0; i < SCP_NREG; i++) begin
            rd(SCP_ADDR[i], mdl[i], fw);
        end
    endtask

    task automatic mdl_defaults();
        for (int i = 0; i < SCP_NREG; i++) begin
            mdl[i] = SCP_DEF[i];
        end
        mdl[SCP_IDX_TEMP] = {7'h00, temp};
    endtask

    // Compares every read result against the oldest expected note.
    always @(posedge clk_i) begin
        if (ack === 1'b1 && cyc && !we && adr === SCP_WB_RDATA) begin
            check("rdata", exp_q.pop_front(), rdat[15:0]);
        end
    end

    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    initial begin
        rst_i = 1'b1;
        {cyc, stb, we, sel, adr, wdat} = '0;
        failures = 0;
        cmp_count = 0;
        seed = xs(32'h5bf1);
        temp = seed[8:0];
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        mdl_defaults();
        rdall(1'b0);
        for (int i = 0; i < SCP_NREG; i++) begin
            seed = xs(seed);
            v = (i == 0) ? (seed[15:0] & 16'h7fff) : seed[15:0];
            v = (v == SCP_RST_KEY) ? ~v : v;
            xfer(1'b0, 1'b0, SCP_ADDR[i], v);
            if (i != SCP_IDX_TEMP && i != SCP_IDX_RST) begin
                mdl[i] = v;
            end
        end
        wb(1'b0, SCP_WB_WDATA, 32'h0);
        check("wdata", v, last[15:0]);
        rdall(1'b0);
        check("dec_en", {15'h0, mdl[0][14]}, {15'h0, dec_en});
        check("band", {15'h0, mdl[0][12]}, {15'h0, band_sel});
        check("four", 16'h0000, {15'h0, four_wire});
        xfer(1'b0, 1'b0, 7'h7f, seed[31:16]);
        rd(7'h7f, 16'h0000, 1'b0);
        xfer(1'b0, 1'b0, 7'h2c, SCP_RST_KEY);
        mdl_defaults();
        rdall(1'b0);
        seed = xs(seed);
        xfer(1'b0, 1'b0, 7'h01, seed[15:0]);
        wb(1'b1, SCP_WB_CTRL, 32'h00000008);
        repeat (10) @(posedge clk_i);
        wb(1'b1, SCP_WB_CTRL, 32'h00000000);
        rd(7'h01, SCP_DEF[1], 1'b0);
        v = 16'h8000 | (seed[31:16] & 16'h5000);
        xfer(1'b0, 1'b0, 7'h00, v);
        mdl[0] = v;
        check("four", 16'h0001, {15'h0, four_wire});
        xfer(1'b0, 1'b1, 7'h03, seed[15:0]);
        mdl[3] = seed[15:0];
        rdall(1'b1);
        @(posedge clk_i);
        complete_run();
    end
endmodule
